// ---- src/dual_timer.sv ----
// Two legacy counter/timers, shared prescaler and clock-select bits
`timescale 1ns/1ps
`default_nettype none
`include "dual_timer_params.svh"

// Functional notes
// - Prescale field picks 12, 4, 48, ext/8
// - Timer one clock select: prescale or sysclk
// - Timer zero clock select: prescale or sysclk
// - Timers two/three byte selects pick sysclk
// - Same byte selects for timers four/five
// - Upper nibble of extended register reads zero
// - 13-bit count: high byte, low five bits
// - 13-bit wrap sets overflow, requests interrupt
// - Counter select counts falling pin edges
// - Run and (no gate or active input)
// - Run bit never clears the count
// - Timer one mirrors timer zero, input one
// - Mode 1 counts all sixteen bits
// - Auto-reload low byte from high byte
// - Split: low byte uses timer zero controls
// - Split: high byte timer, timer one run/flag
// - Split: timer one no pins, no flag
// - Split: timer one runs unless mode three
// - Mode field decode of four modes
// - Flags cleared by software or vectoring
module dual_timer
	import dual_timer_pkg::*;
(
	// Clock and reset
	input wire logic SYS_CLK,
	input wire logic NRST,
	// Special-function register port
	input wire logic [7:0] SFR_ADDR,
	input wire logic [7:0] SFR_WDATA,
	input wire logic SFR_WR,
	input wire logic SFR_RD,
	output logic [7:0] SFR_RDATA,
	// External pins
	input wire logic TIMER_ZERO_COUNT_PIN,
	input wire logic TIMER_ONE_COUNT_PIN,
	input wire logic EXT_IRQ_ZERO_INPUT,
	input wire logic EXT_IRQ_ONE_INPUT,
	input wire logic EXT_CLOCK,
	// Settings held elsewhere in the core
	input wire logic EXT_IRQ_ZERO_POLARITY,
	input wire logic EXT_IRQ_ONE_POLARITY,
	input wire logic TIMER_ZERO_IRQ_ENABLE,
	input wire logic TIMER_ONE_IRQ_ENABLE,
	input wire logic TIMER_ZERO_VECTOR_ACK,
	input wire logic TIMER_ONE_VECTOR_ACK,
	// Timers two to five clock selection
	input wire logic [3:0] EXT_SELECT_TICK,
	input wire logic [3:0] SPLIT_MODE,
	output logic [3:0] LOW_BYTE_TICK,
	output logic [3:0] HIGH_BYTE_TICK,
	// Results
	output logic TIMER_ZERO_IRQ,
	output logic TIMER_ONE_IRQ,
	output logic TIMER_ONE_OVF_PULSE,
	output logic [3:0] EXT_IRQ_CTRL
);

	// ----------------------------------------
	// Reset release
	// ----------------------------------------
	logic rst_meta_q, rst_n;

	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			rst_meta_q <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n <= rst_meta_q;
		end
	end

	// ----------------------------------------
	// Input synchronisation
	// ----------------------------------------
	logic [4:0] pin_level, pin_fall;

	pin_sync #(
		.WIDTH(5),
		.IDLE(5'h1F)
	) u_sync (
		.clk(SYS_CLK),
		.rst_n(rst_n),
		.pin({EXT_CLOCK, EXT_IRQ_ONE_INPUT, EXT_IRQ_ZERO_INPUT,
			TIMER_ONE_COUNT_PIN, TIMER_ZERO_COUNT_PIN}),
		.level(pin_level),
		.fall(pin_fall)
	);

	// ----------------------------------------
	// Register state
	// ----------------------------------------
	logic [7:0] ctrl_q, ctrl_d;
	logic [7:0] mode_q, mode_d;
	logic [7:0] clk_q, clk_d;
	logic [3:0] clk_ext_q, clk_ext_d;
	logic [7:0] lo0_q, lo0_d, hi0_q, hi0_d;
	logic [7:0] lo1_q, lo1_d, hi1_q, hi1_d;
	logic [7:0] rdata_q, rdata_d;
	logic ovf_pulse_q, ovf_pulse_d;

	// ----------------------------------------
	// Field decode
	// ----------------------------------------
	timer_mode_t mode0, mode1;
	prescale_t pre_sel;
	logic presc_tick, split;
	logic act0, act1, en0, en1, en0h;
	logic tick0, tick1, tick0h;
	logic ovf0, ovf1, ovf0h;
	logic [16:0] step0, step1;
	logic [8:0] inc_lo0, inc_hi0;
	logic wr_ctrl;

	assign mode0 = timer_mode_t'(mode_q[`POS_T0_MODE +: 2]);
	assign mode1 = timer_mode_t'(mode_q[`POS_T1_MODE +: 2]);
	assign split = (mode0 == MODE_SPLIT);
	assign pre_sel = prescale_t'(clk_q[`POS_PRESCALE +: 2]);

	timer_prescaler u_presc (
		.clk(SYS_CLK),
		.rst_n(rst_n),
		.sel(pre_sel),
		.ext_fall(pin_fall[4]),
		.tick(presc_tick)
	);

	// gate input taken at its polarity
	assign act0 = EXT_IRQ_ZERO_POLARITY ? pin_level[2] : ~pin_level[2];
	// timer one gated by input one
	assign act1 = EXT_IRQ_ONE_POLARITY ? pin_level[3] : ~pin_level[3];

	assign en0 = ctrl_q[`POS_T0_RUN] & (~mode_q[`POS_T0_GATE] | act0);
	// split: timer one runs from its mode only
	always_comb begin
		if (split) begin
			en1 = (mode1 != MODE_SPLIT);
		end else begin
			en1 = ctrl_q[`POS_T1_RUN] & (~mode_q[`POS_T1_GATE] | act1)
				& (mode1 != MODE_SPLIT);
		end
	end
	// high byte enabled by timer one run
	assign en0h = split & ctrl_q[`POS_T1_RUN];

	assign tick0 = mode_q[`POS_T0_CNT] ? pin_fall[0]
		: (clk_q[`POS_T0_CLKSEL] | presc_tick);
	// timer one clock, no pin in split
	assign tick1 = (mode_q[`POS_T1_CNT] & ~split) ? pin_fall[1]
		: (clk_q[`POS_T1_CLKSEL] | presc_tick);
	// high byte only sysclk or prescaled
	assign tick0h = clk_q[`POS_T0_CLKSEL] | presc_tick;

	// ----------------------------------------
	// Count step for modes 0 to 2
	// ----------------------------------------
	function automatic logic [16:0] count_step(input timer_mode_t m,
		input logic [7:0] hi, input logic [7:0] lo);
		logic [16:0] r;
		logic [13:0] s13;
		logic [16:0] s16;
		logic [8:0] s8;
		r = {1'b0, hi, lo};
		s13 = {1'b0, hi, lo[4:0]} + 14'h0001;
		s16 = {1'b0, hi, lo} + 17'h00001;
		s8 = {1'b0, lo} + 9'h001;
		case (m)
			// 13-bit count, upper low bits untouched
			MODE_13BIT: r = {s13[13], s13[12:5], lo[7:5], s13[4:0]};
			MODE_16BIT: r = s16;
			// reload low from high on wrap
			MODE_RELOAD: r = {s8[8], hi, s8[8] ? hi : s8[7:0]};
			default: r = {1'b0, hi, lo};
		endcase
		return r;
	endfunction

	assign step0 = count_step(mode0, hi0_q, lo0_q);
	assign step1 = count_step(mode1, hi1_q, lo1_q);
	assign inc_lo0 = {1'b0, lo0_q} + 9'h001;
	assign inc_hi0 = {1'b0, hi0_q} + 9'h001;
	assign wr_ctrl = SFR_WR & (SFR_ADDR == `ADDR_RUN_FLAG);

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	always_comb begin
		ctrl_d = ctrl_q;
		mode_d = mode_q;
		clk_d = clk_q;
		clk_ext_d = clk_ext_q;
		lo0_d = lo0_q;
		hi0_d = hi0_q;
		lo1_d = lo1_q;
		hi1_d = hi1_q;
		ovf0 = 1'b0;
		ovf1 = 1'b0;
		ovf0h = 1'b0;

		if (en0 & tick0) begin
			if (split) begin
				// split low byte with timer zero controls
				lo0_d = inc_lo0[7:0];
				ovf0 = inc_lo0[8];
			end else begin
				ovf0 = step0[16];
				hi0_d = step0[15:8];
				lo0_d = step0[7:0];
			end
		end
		// high byte as second 8-bit timer
		if (en0h & tick0h) begin
			hi0_d = inc_hi0[7:0];
			ovf0h = inc_hi0[8];
		end
		// timer one same as timer zero
		if (en1 & tick1) begin
			ovf1 = step1[16];
			hi1_d = step1[15:8];
			lo1_d = step1[7:0];
		end

		// Software writes to a byte win over the count
		if (SFR_WR) begin
			case (SFR_ADDR)
				`ADDR_RUN_FLAG: ctrl_d = SFR_WDATA;
				`ADDR_MODE: mode_d = SFR_WDATA;
				`ADDR_T0_LOW: lo0_d = SFR_WDATA;
				`ADDR_T1_LOW: lo1_d = SFR_WDATA;
				`ADDR_T0_HIGH: hi0_d = SFR_WDATA;
				`ADDR_T1_HIGH: hi1_d = SFR_WDATA;
				`ADDR_CLK_CTRL: clk_d = SFR_WDATA;
				`ADDR_CLK_CTRL_EXT: clk_ext_d = SFR_WDATA[3:0];
				default: ;
			endcase
		end

		// flags cleared by software or vectoring
		if (TIMER_ZERO_VECTOR_ACK) begin
			ctrl_d[`POS_T0_OVF] = 1'b0;
		end
		if (TIMER_ONE_VECTOR_ACK) begin
			ctrl_d[`POS_T1_OVF] = 1'b0;
		end
		// overflow sets flag, set wins over clear
		if (ovf0) begin
			ctrl_d[`POS_T0_OVF] = 1'b1;
		end
		// timer one flag from high byte in split
		if (split ? ovf0h : ovf1) begin
			ctrl_d[`POS_T1_OVF] = 1'b1;
		end

		ovf_pulse_d = ovf1;

		rdata_d = rdata_q;
		if (SFR_RD) begin
			case (SFR_ADDR)
				`ADDR_RUN_FLAG: rdata_d = ctrl_q;
				`ADDR_MODE: rdata_d = mode_q;
				`ADDR_T0_LOW: rdata_d = lo0_q;
				`ADDR_T1_LOW: rdata_d = lo1_q;
				`ADDR_T0_HIGH: rdata_d = hi0_q;
				`ADDR_T1_HIGH: rdata_d = hi1_q;
				`ADDR_CLK_CTRL: rdata_d = clk_q;
				`ADDR_CLK_CTRL_EXT: rdata_d = {4'h0, clk_ext_q}
					& `CLK_CTRL_EXT_MASK;
				default: rdata_d = 8'h00;
			endcase
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q <= `RESET_BYTE;
			mode_q <= `RESET_BYTE;
			clk_q <= `RESET_BYTE;
			clk_ext_q <= 4'h0;
			lo0_q <= `RESET_BYTE;
			hi0_q <= `RESET_BYTE;
			lo1_q <= `RESET_BYTE;
			hi1_q <= `RESET_BYTE;
			rdata_q <= `RESET_BYTE;
			ovf_pulse_q <= 1'b0;
		end else begin
			ctrl_q <= ctrl_d;
			mode_q <= mode_d;
			clk_q <= clk_d;
			clk_ext_q <= clk_ext_d;
			lo0_q <= lo0_d;
			hi0_q <= hi0_d;
			lo1_q <= lo1_d;
			hi1_q <= hi1_d;
			rdata_q <= rdata_d;
			ovf_pulse_q <= ovf_pulse_d;
		end
	end

	// ----------------------------------------
	// Timers two to five clock selection
	// ----------------------------------------
	logic [3:0] low_sel, high_sel;

	assign low_sel = {clk_ext_q[2], clk_ext_q[0], clk_q[6], clk_q[4]};
	assign high_sel = {clk_ext_q[3], clk_ext_q[1], clk_q[7], clk_q[5]};

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_sel
			// set picks sysclk, else own choice
			assign LOW_BYTE_TICK[gi] = low_sel[gi] | EXT_SELECT_TICK[gi];
			// High byte selection matters only when split
			assign HIGH_BYTE_TICK[gi] = SPLIT_MODE[gi]
				& (high_sel[gi] | EXT_SELECT_TICK[gi]);
		end
	endgenerate

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// interrupt request while flag and enable
	assign TIMER_ZERO_IRQ = ctrl_q[`POS_T0_OVF] & TIMER_ZERO_IRQ_ENABLE;
	assign TIMER_ONE_IRQ = ctrl_q[`POS_T1_OVF] & TIMER_ONE_IRQ_ENABLE;
	// Still usable for baud rates while split
	assign TIMER_ONE_OVF_PULSE = ovf_pulse_q;
	assign EXT_IRQ_CTRL = ctrl_q[3:0];
	assign SFR_RDATA = rdata_q;

endmodule
`default_nettype wire

// ---- src/dual_timer_params.svh ----
// Register addresses, field positions, reset values and divisors
`ifndef DUAL_TIMER_PARAMS_SVH
`define DUAL_TIMER_PARAMS_SVH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define ADDR_RUN_FLAG 8'h88
`define ADDR_MODE 8'h89
`define ADDR_T0_LOW 8'h8A
`define ADDR_T1_LOW 8'h8B
`define ADDR_T0_HIGH 8'h8C
`define ADDR_T1_HIGH 8'h8D
`define ADDR_CLK_CTRL 8'h8E
`define ADDR_CLK_CTRL_EXT 8'hE4

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RESET_BYTE 8'h00
`define CLK_CTRL_EXT_MASK 8'h0F

// ----------------------------------------
// Field positions
// ----------------------------------------
`define POS_T1_OVF 7
`define POS_T1_RUN 6
`define POS_T0_OVF 5
`define POS_T0_RUN 4
`define POS_T1_GATE 7
`define POS_T1_CNT 6
`define POS_T1_MODE 4
`define POS_T0_GATE 3
`define POS_T0_CNT 2
`define POS_T0_MODE 0
`define POS_T1_CLKSEL 3
`define POS_T0_CLKSEL 2
`define POS_PRESCALE 0

// ----------------------------------------
// Prescaler divisors
// ----------------------------------------
`define DIV_SEL_12 12
`define DIV_SEL_4 4
`define DIV_SEL_48 48
`define DIV_EXT_8 8

`endif

// ---- src/dual_timer_pkg.sv ----
// Types shared by the dual timer design
package dual_timer_pkg;

	typedef enum logic [1:0] {
		MODE_13BIT = 2'h0,
		MODE_16BIT = 2'h1,
		MODE_RELOAD = 2'h2,
		MODE_SPLIT = 2'h3
	} timer_mode_t;

	typedef enum logic [1:0] {
		PRE_DIV12 = 2'h0,
		PRE_DIV4 = 2'h1,
		PRE_DIV48 = 2'h2,
		PRE_EXT8 = 2'h3
	} prescale_t;

endpackage

// ---- src/pin_sync.sv ----
// Two-stage synchroniser with falling-edge detect for input pins
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
	parameter int WIDTH = 5,
	parameter logic [WIDTH-1:0] IDLE = '1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Pins and synchronised views
	input wire logic [WIDTH-1:0] pin,
	output logic [WIDTH-1:0] level,
	output logic [WIDTH-1:0] fall
);

	logic [WIDTH-1:0] meta_q, meta_d;
	logic [WIDTH-1:0] sync_q, sync_d;
	logic [WIDTH-1:0] prev_q, prev_d;

	always_comb begin
		meta_d = pin;
		sync_d = meta_q;
		prev_d = sync_q;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= IDLE;
			sync_q <= IDLE;
			prev_q <= IDLE;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
			prev_q <= prev_d;
		end
	end

	assign level = sync_q;
	// Edge seen only in the synchronised domain, one per cycle at most
	assign fall = prev_q & ~sync_q;

endmodule
`default_nettype wire

// ---- src/timer_prescaler.sv ----
// Shared prescaler producing one-cycle ticks for the two timers
`timescale 1ns/1ps
`default_nettype none
`include "dual_timer_params.svh"
module timer_prescaler
	import dual_timer_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Control
	input wire prescale_t sel,
	input wire logic ext_fall,
	// Tick
	output logic tick
);

	logic [5:0] cnt_q, cnt_d;
	logic tick_q, tick_d;
	logic [5:0] limit;
	logic step;

	always_comb begin
		case (sel)
			PRE_DIV12: limit = 6'(`DIV_SEL_12 - 1);
			PRE_DIV4: limit = 6'(`DIV_SEL_4 - 1);
			PRE_DIV48: limit = 6'(`DIV_SEL_48 - 1);
			PRE_EXT8: limit = 6'(`DIV_EXT_8 - 1);
			default: limit = 6'(`DIV_SEL_12 - 1);
		endcase
		step = (sel == PRE_EXT8) ? ext_fall : 1'b1;
		cnt_d = cnt_q;
		tick_d = 1'b0;
		if (step) begin
			// >= so a change of divisor never strands the counter
			if (cnt_q >= limit) begin
				cnt_d = 6'h00;
				tick_d = 1'b1;
			end else begin
				cnt_d = cnt_q + 6'h01;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 6'h00;
			tick_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			tick_q <= tick_d;
		end
	end

	assign tick = tick_q;

endmodule
`default_nettype wire

// ---- testbench/dual_timer_checker.sv ----
// Port assertions for the dual timer
`timescale 1ns/1ps
`default_nettype none
module dual_timer_checker (
	// Clock and reset
	input wire logic SYS_CLK,
	input wire logic NRST,
	// Register port
	input wire logic [7:0] SFR_ADDR,
	input wire logic [7:0] SFR_WDATA,
	input wire logic SFR_WR,
	input wire logic SFR_RD,
	input wire logic [7:0] SFR_RDATA,
	// Interrupt side
	input wire logic TIMER_ZERO_IRQ_ENABLE,
	input wire logic TIMER_ONE_IRQ_ENABLE,
	input wire logic TIMER_ZERO_VECTOR_ACK,
	input wire logic TIMER_ONE_VECTOR_ACK,
	input wire logic TIMER_ZERO_IRQ,
	input wire logic TIMER_ONE_IRQ,
	input wire logic TIMER_ONE_OVF_PULSE,
	// Clock selects of the other timers
	input wire logic [3:0] EXT_SELECT_TICK,
	input wire logic [3:0] SPLIT_MODE,
	input wire logic [3:0] LOW_BYTE_TICK,
	input wire logic [3:0] HIGH_BYTE_TICK
);
	// ------------------------------
	// Shadows of software-only registers
	// ------------------------------
	logic [7:0] ck0_q, ck0_d, ck1_q, ck1_d, md_q, md_d;
	logic [3:0] lo_sel, hi_sel;

	assign lo_sel = {ck1_q[2], ck1_q[0], ck0_q[6], ck0_q[4]};
	assign hi_sel = {ck1_q[3], ck1_q[1], ck0_q[7], ck0_q[5]};

	always_comb begin
		ck0_d = ck0_q;
		ck1_d = ck1_q;
		md_d = md_q;
		if (SFR_WR && SFR_ADDR == 8'h8E)
			ck0_d = SFR_WDATA;
		if (SFR_WR && SFR_ADDR == 8'hE4)
			ck1_d = {4'h0, SFR_WDATA[3:0]};
		if (SFR_WR && SFR_ADDR == 8'h89)
			md_d = SFR_WDATA;
	end

	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			ck0_q <= 8'h00;
			ck1_q <= 8'h00;
			md_q <= 8'h00;
		end else begin
			ck0_q <= ck0_d;
			ck1_q <= ck1_d;
			md_q <= md_d;
		end
	end

	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!NRST);

	a_ext_upper_zero: assert property (
		SFR_RD && !SFR_WR && SFR_ADDR == 8'hE4 |=> SFR_RDATA == ck1_q)
		else $error("extended select readback wrong");
	a_timer_clock_control_readback: assert property (
		SFR_RD && !SFR_WR && SFR_ADDR == 8'h8E |=> SFR_RDATA == ck0_q)
		else $error("clock control readback wrong");
	a_low_tick_sel: assert property (
		LOW_BYTE_TICK == (lo_sel | EXT_SELECT_TICK))
		else $error("low byte tick wrong");
	a_high_tick_sel: assert property (
		HIGH_BYTE_TICK == (SPLIT_MODE & (hi_sel | EXT_SELECT_TICK)))
		else $error("high byte tick wrong");
	a_zero_irq_enable: assert property (
		TIMER_ZERO_IRQ |-> TIMER_ZERO_IRQ_ENABLE)
		else $error("timer zero request while disabled");
	a_one_irq_enable: assert property (
		TIMER_ONE_IRQ |-> TIMER_ONE_IRQ_ENABLE)
		else $error("timer one request while disabled");
	a_zero_flag_cause: assert property (
		$fell(TIMER_ZERO_IRQ) && $past(TIMER_ZERO_IRQ_ENABLE) &&
		TIMER_ZERO_IRQ_ENABLE |-> $past(TIMER_ZERO_VECTOR_ACK) ||
		$past(SFR_WR) && $past(SFR_ADDR) == 8'h88)
		else $error("timer zero flag cleared without cause");
	a_one_flag_cause: assert property (
		$fell(TIMER_ONE_IRQ) && $past(TIMER_ONE_IRQ_ENABLE) &&
		TIMER_ONE_IRQ_ENABLE |-> $past(TIMER_ONE_VECTOR_ACK) ||
		$past(SFR_WR) && $past(SFR_ADDR) == 8'h88)
		else $error("timer one flag cleared without cause");
	a_ovf_sets_flag: assert property (
		TIMER_ONE_OVF_PULSE && TIMER_ONE_IRQ_ENABLE && md_q[1:0] != 2'h3
		|-> ##[0:1] TIMER_ONE_IRQ)
		else $error("timer one wrap left flag clear");
endmodule

bind dual_timer dual_timer_checker chk_u (.SYS_CLK, .NRST, .SFR_ADDR,
	.SFR_WDATA, .SFR_WR, .SFR_RD, .SFR_RDATA, .TIMER_ZERO_IRQ_ENABLE,
	.TIMER_ONE_IRQ_ENABLE, .TIMER_ZERO_VECTOR_ACK, .TIMER_ONE_VECTOR_ACK,
	.TIMER_ZERO_IRQ, .TIMER_ONE_IRQ, .TIMER_ONE_OVF_PULSE, .EXT_SELECT_TICK,
	.SPLIT_MODE, .LOW_BYTE_TICK, .HIGH_BYTE_TICK);
`default_nettype wire

// ---- testbench/pin_source_model.sv ----
// External count pins, gate inputs and external clock source
`timescale 1ns/1ps
`default_nettype none
module pin_source_model (
	// Clock
	input wire logic clk,
	// Pins towards the timers
	output logic count_zero,
	output logic count_one,
	output logic gate_zero,
	output logic gate_one,
	output logic ext_clk
);
	// Count and clock pins idle high so a first pulse is a clean fall; gate pins idle low
	logic [2:0] lvl = 3'h7;
	logic [1:0] gt = 2'h0;

	assign count_zero = lvl[0];
	assign count_one = lvl[1];
	assign ext_clk = lvl[2];
	assign gate_zero = gt[0];
	assign gate_one = gt[1];

	task automatic pulse(input int pin, input int n);
		repeat (2 * n) begin
			repeat (3) @(posedge clk);
			#1 lvl[pin] = ~lvl[pin];
		end
		repeat (3) @(posedge clk);
		#1;
	endtask

	task automatic gate(input logic z, input logic o);
		@(posedge clk);
		#1 gt = {o, z};
	endtask
endmodule
`default_nettype wire

// ---- testbench/test_dual_timer.sv ----
// Self-checking bench for the dual timer
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
	fails++; $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module test_dual_timer;
	logic SYS_CLK = 1'b0;
	logic NRST = 1'b0;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, v, w;
	logic wr = 1'b0, rd = 1'b0, ack0 = 1'b0, ack1 = 1'b0;
	logic pol0 = 1'b1, pol1 = 1'b1, ie0 = 1'b1, ie1 = 1'b1;
	logic [3:0] xsel = 4'h0, split = 4'h0, lo_tick, hi_tick;
	logic irq0, irq1, ovf1, t0p, t1p, g0, g1, xclk;
	logic [3:0] xctl;
	int fails = 0;
	int comparisons = 0;
	int e;
	int div [4] = '{12, 4, 48, 8};
	logic [7:0] regs [9] = '{8'h88, 8'h89, 8'h8A, 8'h8B, 8'h8C, 8'h8D,
		8'h8E, 8'hE4, 8'h90};

	always #5 SYS_CLK = ~SYS_CLK;

	dual_timer dut_u (
		.SYS_CLK(SYS_CLK), .NRST(NRST), .SFR_ADDR(addr),
		.SFR_WDATA(wdata), .SFR_WR(wr), .SFR_RD(rd), .SFR_RDATA(rdata),
		.TIMER_ZERO_COUNT_PIN(t0p), .TIMER_ONE_COUNT_PIN(t1p),
		.EXT_IRQ_ZERO_INPUT(g0), .EXT_IRQ_ONE_INPUT(g1), .EXT_CLOCK(xclk),
		.EXT_IRQ_ZERO_POLARITY(pol0), .EXT_IRQ_ONE_POLARITY(pol1),
		.TIMER_ZERO_IRQ_ENABLE(ie0), .TIMER_ONE_IRQ_ENABLE(ie1),
		.TIMER_ZERO_VECTOR_ACK(ack0), .TIMER_ONE_VECTOR_ACK(ack1),
		.EXT_SELECT_TICK(xsel), .SPLIT_MODE(split),
		.LOW_BYTE_TICK(lo_tick), .HIGH_BYTE_TICK(hi_tick),
		.TIMER_ZERO_IRQ(irq0), .TIMER_ONE_IRQ(irq1),
		.TIMER_ONE_OVF_PULSE(ovf1), .EXT_IRQ_CTRL(xctl));

	pin_source_model pm_u (.clk(SYS_CLK), .count_zero(t0p),
		.count_one(t1p), .gate_zero(g0), .gate_one(g1), .ext_clk(xclk));

	// ------------------------------
	// Register access and reporting
	// ------------------------------
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge SYS_CLK);
		#1 addr = a;
		wdata = d;
		wr = 1'b1;
		@(posedge SYS_CLK);
		#1 wr = 1'b0;
	endtask

	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge SYS_CLK);
		#1 addr = a;
		rd = 1'b1;
		@(posedge SYS_CLK);
		#1 rd = 1'b0;
		d = rdata;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] x);
		rd_reg(a, v);
		`CHK($sformatf("reg %0h", a), x, v)
	endtask

	// One-cycle vectoring pulse for timer zero (0) or timer one (1)
	task automatic vec_ack(input logic one);
		@(posedge SYS_CLK);
		#1 ack0 = ~one;
		ack1 = one;
		@(posedge SYS_CLK);
		#1 ack0 = 1'b0;
		ack1 = 1'b0;
	endtask

	task automatic done(input string n);
		$display("test %s finished", n);
	endtask

	task automatic conclude();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge SYS_CLK);
		fails++;
		conclude();
	end

	initial begin
		repeat (20) @(posedge SYS_CLK);
		#1 NRST = 1'b1;
		repeat (4) @(posedge SYS_CLK);
		foreach (regs[i])
			rd_chk(regs[i], 8'h00);
		wr_reg(8'h88, 8'h0A);
		`CHK("irq ctrl", 4'hA, xctl)
		rd_chk(8'h88, 8'h0A);
		wr_reg(8'h88, 8'h00);
		wr_reg(8'h8E, 8'hFF);
		rd_chk(8'h8E, 8'hFF);
		wr_reg(8'hE4, 8'hFF);
		rd_chk(8'hE4, 8'h0F);
		wr_reg(8'h8E, 8'h50);
		wr_reg(8'hE4, 8'h0A);
		@(posedge SYS_CLK);
		#1 split = 4'hF;
		#1 `CHK("low tick", 4'h3, lo_tick)
		`CHK("high tick", 4'hC, hi_tick)
		@(posedge SYS_CLK);
		#1 split = 4'h0;
		xsel = 4'hF;
		#1 `CHK("high off", 4'h0, hi_tick)
		`CHK("low ext", 4'hF, lo_tick)
		done("selects");
		for (int s = 0; s < 4; s++) begin
			wr_reg(8'h8E, 8'(s));
			wr_reg(8'h89, 8'h01);
			wr_reg(8'h8A, 8'h00);
			wr_reg(8'h8C, 8'h00);
			wr_reg(8'h88, 8'h10);
			if (s == 3)
				pm_u.pulse(2, 80);
			else
				repeat (480) @(posedge SYS_CLK);
			wr_reg(8'h88, 8'h00);
			rd_reg(8'h8A, v);
			e = (s == 3) ? 80 / div[3] : 480 / div[s];
			`CHK("prescale", 1'b1, v >= e - 1 && v <= e + 1)
		end
		done("prescaler");
		wr_reg(8'h8E, 8'h04);
		wr_reg(8'h8A, 8'hF0);
		wr_reg(8'h8C, 8'hFF);
		wr_reg(8'h88, 8'h10);
		repeat (10) @(posedge SYS_CLK);
		#1 `CHK("early flag", 1'b0, irq0)
		repeat (10) @(posedge SYS_CLK);
		#1 `CHK("wrap flag", 1'b1, irq0)
		ie0 = 1'b0;
		@(posedge SYS_CLK);
		#1 `CHK("masked", 1'b0, irq0)
		ie0 = 1'b1;
		wr_reg(8'h88, 8'h20);
		rd_chk(8'h8C, 8'h00);
		vec_ack(1'b0);
		`CHK("acked", 1'b0, irq0)
		done("sixteen bit");
		wr_reg(8'h89, 8'h04);
		wr_reg(8'h8A, 8'hFE);
		wr_reg(8'h8C, 8'hFF);
		wr_reg(8'h88, 8'h10);
		pm_u.pulse(0, 1);
		`CHK("no wrap", 1'b0, irq0)
		pm_u.pulse(0, 1);
		`CHK("wrap13", 1'b1, irq0)
		rd_chk(8'h8C, 8'h00);
		rd_reg(8'h8A, v);
		`CHK("low five", 8'h00, v & 8'h1F)
		wr_reg(8'h88, 8'h00);
		wr_reg(8'h89, 8'h0C);
		wr_reg(8'h8A, 8'h00);
		wr_reg(8'h88, 8'h10);
		for (int k = 0; k < 3; k++) begin
			pm_u.gate(k > 0, 1'b0);
			pol0 = (k < 2);
			pm_u.pulse(0, 2);
			rd_reg(8'h8A, v);
			`CHK("gated", k > 0 ? 8'h02 : 8'h00, v & 8'h1F)
		end
		done("pin counting");
		wr_reg(8'h88, 8'h00);
		wr_reg(8'h89, 8'h60);
		wr_reg(8'h8D, 8'hFD);
		wr_reg(8'h8B, 8'hFE);
		wr_reg(8'h88, 8'h40);
		pm_u.pulse(1, 2);
		`CHK("reload flag", 1'b1, irq1)
		rd_chk(8'h8B, 8'hFD);
		rd_chk(8'h8D, 8'hFD);
		vec_ack(1'b1);
		`CHK("acked one", 1'b0, irq1)
		wr_reg(8'h89, 8'hE0);
		pm_u.pulse(1, 1);
		rd_chk(8'h8B, 8'hFD);
		pm_u.gate(1'b0, 1'b1);
		pm_u.pulse(1, 1);
		rd_chk(8'h8B, 8'hFE);
		done("reload");
		wr_reg(8'h88, 8'h00);
		wr_reg(8'h8E, 8'h0C);
		wr_reg(8'h8B, 8'h1C);
		wr_reg(8'h8D, 8'hFF);
		wr_reg(8'h8C, 8'hF0);
		wr_reg(8'h89, 8'h03);
		for (int i = 0; i < 40 && ovf1 !== 1'b1; i++) begin
			@(posedge SYS_CLK);
			#1;
		end
		`CHK("t1 ovf", 1'b1, ovf1)
		repeat (2) @(posedge SYS_CLK);
		#1 `CHK("t1 no flag", 1'b0, irq1)
		wr_reg(8'h88, 8'h40);
		repeat (20) @(posedge SYS_CLK);
		#1 `CHK("high flag", 1'b1, irq1)
		wr_reg(8'h89, 8'h33);
		rd_reg(8'h8B, w);
		repeat (20) @(posedge SYS_CLK);
		rd_chk(8'h8B, w);
		done("split");
		conclude();
	end
endmodule
`default_nettype wire
